// ==== src/can_interrupt_mask_flag_logic.sv ====
// Functional notes
// - a global flag pulses the global line only while its mask bit is 1.
// - reset clears the whole global event mask to zero.
// - mask bits 7..0: remote, wake, rx lost, tx abort, stamp ovf, bus off, passive, warning.
// - transmit and receive mailbox lines are separate from the global line.
// - mailbox enable register holds one bit per mailbox 0 to 15.
// - mailbox 15 has no transmit flag; that bit stays empty.
// - transmit flag of a receive mailbox always reads 0.
// - enabled transmit sets flag; pulse transmit line if no flag was set.
// - disabled mailbox transmit neither sets flag nor pulses.
// - with transmit flags already set, new flag sets but no pulse.
// - partial clear of transmit flags leaving some set gives new pulse.
// - write 1 clears transmit flag, write 0 leaves it.
// - receive flag of a transmit mailbox always reads 0.
// - enabled reception sets flag; pulse receive line if no flag was set.
// - disabled mailbox reception neither sets flag nor pulses.
// - with receive flags already set, new flag sets but no pulse.
// - partial clear of receive flags leaving some set gives new pulse.
// - write 1 clears receive flag, write 0 leaves it.
// - global flags set on event, cleared by write 1; same pulse rules.
//
// Added by the designer: register access over Avalon-MM.
`include "can_irq_params.svh"

module can_interrupt_mask_flag_logic #(
   parameter int NUM_MBOX = 16,
   parameter int NUM_GEV  = 8
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [11:0]            address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [3:0]             byteenable,
   input  wire logic [31:0]            writedata,
   output logic      [31:0]            readdata,
   output logic                        waitrequest,
   input  wire can_irq_pkg::gevVec_t   globalEvent,
   input  wire can_irq_pkg::mboxVec_t  txDone,
   input  wire can_irq_pkg::mboxVec_t  rxDone,
   input  wire can_irq_pkg::mboxVec_t  mboxIsRx,
   output logic                        globalIrqLine,
   output logic                        mailboxTxIrqLine,
   output logic                        mailboxRxIrqLine
);
   import can_irq_pkg::*;

   // register map and port types are fixed; other sizes would leave bits unmapped
   if (NUM_MBOX != $bits(mboxVec_t)) begin : gen_bad_mbox
      $error("mailbox count must match the 16-bit mailbox vector");
   end
   if (NUM_GEV != $bits(gevVec_t)) begin : gen_bad_gev
      $error("global event count must match the 8-bit event vector");
   end

   // decode a byte address into a register select
   function automatic regSel_t decodeSel(input logic [11:0] a);
      regSel_t s;
      s = SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[11:2])
            `CIR_IDX_GFLAG_LO: s = SEL_GFLAG_LO;
            `CIR_IDX_GFLAG_HI: s = SEL_GFLAG_HI;
            `CIR_IDX_GMASK_LO: s = SEL_GMASK_LO;
            `CIR_IDX_GMASK_HI: s = SEL_GMASK_HI;
            `CIR_IDX_TXF_LO:   s = SEL_TXF_LO;
            `CIR_IDX_TXF_HI:   s = SEL_TXF_HI;
            `CIR_IDX_RXF_LO:   s = SEL_RXF_LO;
            `CIR_IDX_RXF_HI:   s = SEL_RXF_HI;
            `CIR_IDX_MBEN_LO:  s = SEL_MBEN_LO;
            `CIR_IDX_MBEN_HI:  s = SEL_MBEN_HI;
            default:           s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // pulse on first flag of an empty group, or after a clear that leaves some set
   function automatic logic pulseNeeded(input logic [15:0] old,
                                        input logic [15:0] nxt,
                                        input logic        cleared);
      return ((old == 16'h0000) && (nxt != 16'h0000)) ||
             (cleared && (nxt != 16'h0000));
   endfunction

   logic         ack_reg;
   regSel_t      sel;
   logic         doWrite;
   logic [7:0]   wByte;
   gevVec_t      globalMask_reg;
   gevVec_t      globalFlags_reg;
   gevVec_t      globalFlags_next;
   mboxVec_t     mbEnable_reg;
   mboxVec_t     txFlags_reg;
   mboxVec_t     txFlags_next;
   mboxVec_t     rxFlags_reg;
   mboxVec_t     rxFlags_next;
   mboxVec_t     txClr;
   mboxVec_t     rxClr;
   gevVec_t      gClr;
   mboxVec_t     txSet;
   mboxVec_t     rxSet;
   logic         txCleared;
   logic         rxCleared;
   logic         gCleared;
   logic [15:0]  gEnOld;
   logic [15:0]  gEnNext;
   logic [31:0]  readdata_next;

   // one wait state on every access; the write lands on the answer edge
   assign sel         = decodeSel(address);
   assign waitrequest = (read || write) && !ack_reg;
   assign doWrite     = write && ack_reg && byteenable[0];
   assign wByte       = writedata[7:0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read || write) && !ack_reg;
      end
   end

   // write-one-to-clear masks per group
   always_comb begin
      txClr = `CIR_RST_WORD;
      rxClr = `CIR_RST_WORD;
      gClr  = `CIR_RST_BYTE;
      if (doWrite) begin
         case (sel)
            SEL_TXF_LO:   txClr[7:0]  = wByte;
            SEL_TXF_HI:   txClr[15:8] = wByte;
            SEL_RXF_LO:   rxClr[7:0]  = wByte;
            SEL_RXF_HI:   rxClr[15:8] = wByte;
            SEL_GFLAG_LO: gClr        = wByte;
            default:      ;
         endcase
      end
   end

   // events only set flags of enabled mailboxes; no tx flag on mailbox 15
   always_comb begin
      txSet = txDone & mbEnable_reg;
      txSet[`CIR_RX_ONLY_MBOX] = 1'b0;
      rxSet = rxDone & mbEnable_reg;
   end

   // set beats clear so an event in the clearing cycle survives
   assign txFlags_next     = (txFlags_reg & ~txClr) | txSet;
   assign rxFlags_next     = (rxFlags_reg & ~rxClr) | rxSet;
   assign globalFlags_next = (globalFlags_reg & ~gClr) | globalEvent;

   // a clear only counts when it hits a set flag, even one that a set in the same cycle keeps
   assign txCleared = (txFlags_reg & txClr) != `CIR_RST_WORD;
   assign rxCleared = (rxFlags_reg & rxClr) != `CIR_RST_WORD;
   assign gCleared  = ((globalFlags_reg & globalMask_reg) & gClr) != `CIR_RST_BYTE;

   // only unmasked global flags take part in pulse decisions
   assign gEnOld  = {8'h00, globalFlags_reg & globalMask_reg};
   assign gEnNext = {8'h00, globalFlags_next & globalMask_reg};

   // transmit flag storage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txFlags_reg <= `CIR_RST_WORD;
      end else begin
         txFlags_reg <= txFlags_next;
      end
   end

   // receive flag storage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxFlags_reg <= `CIR_RST_WORD;
      end else begin
         rxFlags_reg <= rxFlags_next;
      end
   end

   // global flag storage; flags set whatever the mask holds
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         globalFlags_reg <= `CIR_RST_BYTE;
      end else begin
         globalFlags_reg <= globalFlags_next;
      end
   end

   // global mask; the high mask byte is reserved and never stored
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         globalMask_reg <= `CIR_RST_BYTE;
      end else if (doWrite && sel == SEL_GMASK_LO) begin
         globalMask_reg <= wByte;
      end
   end

   // mailbox enables, one byte per register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mbEnable_reg <= `CIR_RST_WORD;
      end else if (doWrite) begin
         case (sel)
            SEL_MBEN_LO: mbEnable_reg[7:0]  <= wByte;
            SEL_MBEN_HI: mbEnable_reg[15:8] <= wByte;
            default:     ;
         endcase
      end
   end

   // global line: one-cycle pulse decided from unmasked flags only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         globalIrqLine <= 1'b0;
      end else begin
         globalIrqLine <= pulseNeeded(gEnOld, gEnNext, gCleared);
      end
   end

   // transmit line, separate from the global line
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mailboxTxIrqLine <= 1'b0;
      end else begin
         mailboxTxIrqLine <= pulseNeeded(txFlags_reg, txFlags_next, txCleared);
      end
   end

   // receive line, separate from the global line
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mailboxRxIrqLine <= 1'b0;
      end else begin
         mailboxRxIrqLine <= pulseNeeded(rxFlags_reg, rxFlags_next, rxCleared);
      end
   end

   // read mux; flags of the wrong direction read as zero
   always_comb begin
      readdata_next = 32'h0000_0000;
      case (sel)
         SEL_GFLAG_LO: readdata_next[7:0] = globalFlags_reg;
         SEL_GMASK_LO: readdata_next[7:0] = globalMask_reg;
         SEL_TXF_LO:   readdata_next[7:0] = txFlags_reg[7:0] & ~mboxIsRx[7:0];
         SEL_TXF_HI:   readdata_next[7:0] = txFlags_reg[15:8] & ~mboxIsRx[15:8];
         SEL_RXF_LO:   readdata_next[7:0] = rxFlags_reg[7:0] & mboxIsRx[7:0];
         SEL_RXF_HI:   readdata_next[7:0] = rxFlags_reg[15:8] & mboxIsRx[15:8];
         SEL_MBEN_LO:  readdata_next[7:0] = mbEnable_reg[7:0];
         SEL_MBEN_HI:  readdata_next[7:0] = mbEnable_reg[15:8];
         default:      readdata_next = 32'h0000_0000;
      endcase
   end

   // read data captured in the wait cycle, valid on the answer edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack_reg) begin
         readdata <= readdata_next;
      end
   end

   // checks
   AST_GLOBAL_MASKED: assert property (@(posedge clock) disable iff (!rst_n)
      globalIrqLine |-> (globalFlags_reg & globalMask_reg) != 8'h00)
      else $error("global pulse without an unmasked flag");

   AST_MASK_RESET: assert property (@(posedge clock)
      $rose(rst_n) |-> globalMask_reg == 8'h00)
      else $error("global mask not zero after reset");

   AST_TX15_EMPTY: assert property (@(posedge clock) disable iff (!rst_n)
      txFlags_reg[`CIR_RX_ONLY_MBOX] == 1'b0)
      else $error("transmit flag of mailbox 15 set");

   AST_TX_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      (read && ack_reg && sel == SEL_TXF_LO) |->
         (readdata[7:0] & $past(mboxIsRx[7:0])) == 8'h00)
      else $error("receive mailbox shows a transmit flag");

   AST_TX_SET_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (txFlags_reg == 16'h0000 && txSet != 16'h0000) |=>
         mailboxTxIrqLine && ((txFlags_reg & $past(txSet)) == $past(txSet)))
      else $error("enabled transmit did not set flag and pulse");

   AST_TX_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 ((txFlags_reg & ~$past(txFlags_reg)) & ~$past(mbEnable_reg)) == 16'h0000)
      else $error("disabled mailbox set a transmit flag");

   AST_TX_NO_REPULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (txFlags_reg != 16'h0000 && !txCleared) |=> !mailboxTxIrqLine)
      else $error("extra transmit pulse while flags set");

   AST_TX_REPULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (txCleared && txFlags_next != 16'h0000) |=> mailboxTxIrqLine)
      else $error("no transmit pulse after partial clear");

   AST_TX_W1C: assert property (@(posedge clock) disable iff (!rst_n)
      (doWrite && sel == SEL_TXF_LO) |=>
         (txFlags_reg[7:0] & $past(wByte) & ~$past(txSet[7:0])) == 8'h00)
      else $error("write one did not clear transmit flag");

   AST_RX_SET_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (rxFlags_reg == 16'h0000 && rxSet != 16'h0000) |=> mailboxRxIrqLine)
      else $error("enabled reception did not pulse");

   AST_RX_REPULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (rxCleared && rxFlags_next != 16'h0000) |=> mailboxRxIrqLine)
      else $error("no receive pulse after partial clear");

   AST_PULSE_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
      (mailboxRxIrqLine && !rxCleared) |=> !mailboxRxIrqLine)
      else $error("receive pulse wider than one cycle");

   AST_TX_PULSE_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
      (mailboxTxIrqLine && !txCleared) |=> !mailboxTxIrqLine)
      else $error("transmit pulse wider than one cycle");

   AST_TX_SET_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
      (txSet != 16'h0000) |=> (txFlags_reg & $past(txSet)) == $past(txSet))
      else $error("enabled transmit did not set its flag");

   AST_RX_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 ((rxFlags_reg & ~$past(rxFlags_reg)) & ~$past(mbEnable_reg)) == 16'h0000)
      else $error("disabled mailbox set a receive flag");

   AST_RX_NO_REPULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (rxFlags_reg != 16'h0000 && !rxCleared) |=> !mailboxRxIrqLine)
      else $error("extra receive pulse while flags set");

   AST_RX_SET_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
      (rxSet != 16'h0000) |=> (rxFlags_reg & $past(rxSet)) == $past(rxSet))
      else $error("enabled reception did not set its flag");

   AST_RX_W1C: assert property (@(posedge clock) disable iff (!rst_n)
      (doWrite && sel == SEL_RXF_HI) |=>
         (rxFlags_reg[15:8] & $past(wByte) & ~$past(rxSet[15:8])) == 8'h00)
      else $error("write one did not clear receive flag");

   AST_RX_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      (read && ack_reg && sel == SEL_RXF_LO) |->
         (readdata[7:0] & ~$past(mboxIsRx[7:0])) == 8'h00)
      else $error("transmit mailbox shows a receive flag");

   AST_GLOBAL_SET: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 (globalFlags_reg & $past(globalEvent)) == $past(globalEvent))
      else $error("global event did not set its flag");

   AST_GLOBAL_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
      (gEnOld == 16'h0000 && gEnNext != 16'h0000) |=> globalIrqLine)
      else $error("unmasked global event did not pulse");

   AST_GLOBAL_REPULSE: assert property (@(posedge clock) disable iff (!rst_n)
      (gCleared && gEnNext != 16'h0000) |=> globalIrqLine)
      else $error("no global pulse after partial clear");

   AST_GLOBAL_W1C: assert property (@(posedge clock) disable iff (!rst_n)
      (doWrite && sel == SEL_GFLAG_LO) |=>
         (globalFlags_reg & $past(wByte) & ~$past(globalEvent)) == 8'h00)
      else $error("write one did not clear global flag");

   AST_MBEN_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
      (doWrite && sel == SEL_MBEN_HI) |=> mbEnable_reg[15:8] == $past(wByte))
      else $error("mailbox enable high byte not written");

   AST_TX15_READ: assert property (@(posedge clock) disable iff (!rst_n)
      (read && ack_reg && sel == SEL_TXF_HI) |-> readdata[7] == 1'b0)
      else $error("transmit flag of mailbox 15 read as set");

   AST_RESERVED_READ: assert property (@(posedge clock) disable iff (!rst_n)
      (read && ack_reg && (sel == SEL_GFLAG_HI || sel == SEL_GMASK_HI || sel == SEL_NONE)) |->
         readdata == 32'h0000_0000)
      else $error("reserved or unmapped register read not zero");

   COV_TX_FIRST: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(mailboxTxIrqLine));
   COV_RX_REPULSE: cover property (@(posedge clock) disable iff (!rst_n)
      rxCleared && rxFlags_next != 16'h0000);
   COV_GLOBAL: cover property (@(posedge clock) disable iff (!rst_n)
      globalIrqLine);
   COV_TX_REPULSE: cover property (@(posedge clock) disable iff (!rst_n)
      txCleared && txFlags_next != 16'h0000);
   COV_GLOBAL_REPULSE: cover property (@(posedge clock) disable iff (!rst_n)
      gCleared && gEnNext != 16'h0000);

endmodule // can_interrupt_mask_flag_logic

// ==== src/can_irq_params.svh ====
`ifndef CAN_IRQ_PARAMS_SVH
`define CAN_IRQ_PARAMS_SVH

// register indices; the bus byte address is four times the index
`define CIR_IDX_GFLAG_LO  10'h320
`define CIR_IDX_GFLAG_HI  10'h321
`define CIR_IDX_GMASK_LO  10'h322
`define CIR_IDX_GMASK_HI  10'h323
`define CIR_IDX_TXF_LO    10'h324
`define CIR_IDX_TXF_HI    10'h325
`define CIR_IDX_RXF_LO    10'h326
`define CIR_IDX_RXF_HI    10'h327
`define CIR_IDX_MBEN_LO   10'h328
`define CIR_IDX_MBEN_HI   10'h329

// global mask / flag bit positions
`define CIR_BIT_REMOTE    7
`define CIR_BIT_WAKE      6
`define CIR_BIT_RXLOST    5
`define CIR_BIT_TXABORT   4
`define CIR_BIT_STAMPOVF  3
`define CIR_BIT_BUSOFF    2
`define CIR_BIT_ERRPASS   1
`define CIR_BIT_WARNING   0

// reset values
`define CIR_RST_BYTE      8'h00
`define CIR_RST_WORD      16'h0000

// the receive-only mailbox has no transmit flag
`define CIR_RX_ONLY_MBOX  15

`endif

// ==== src/can_irq_pkg.sv ====
package can_irq_pkg;

   // register select after address decode
   typedef enum {
      SEL_NONE,
      SEL_GFLAG_LO,
      SEL_GFLAG_HI,
      SEL_GMASK_LO,
      SEL_GMASK_HI,
      SEL_TXF_LO,
      SEL_TXF_HI,
      SEL_RXF_LO,
      SEL_RXF_HI,
      SEL_MBEN_LO,
      SEL_MBEN_HI
   } regSel_t;

   typedef logic [15:0] mboxVec_t;
   typedef logic [7:0]  gevVec_t;

endpackage

// ==== testbench/irq_sink_model.sv ====
// stands in for the cpu interrupt controller: counts pulses per line
module irq_sink_model (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic globalIrqLine,
   input  wire logic mailboxTxIrqLine,
   input  wire logic mailboxRxIrqLine,
   output int        nGlobal,
   output int        nTx,
   output int        nRx,
   output int        nWide
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] lineVec;
   logic [2:0] last_reg;

   assign lineVec = {mailboxRxIrqLine, mailboxTxIrqLine, globalIrqLine};

   // edge counting, so a stretched pulse is one request but shows up in nWide
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last_reg <= 3'h0;
         nGlobal  <= 0;
         nTx      <= 0;
         nRx      <= 0;
         nWide    <= 0;
      end else begin
         last_reg <= lineVec;
         nGlobal  <= nGlobal + int'(lineVec[0] & ~last_reg[0]);
         nTx      <= nTx + int'(lineVec[1] & ~last_reg[1]);
         nRx      <= nRx + int'(lineVec[2] & ~last_reg[2]);
         nWide    <= nWide + int'(|(lineVec & last_reg));
      end
   end
endmodule // irq_sink_model

// ==== testbench/can_interrupt_mask_flag_logic_tb.sv ====
module can_interrupt_mask_flag_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import can_irq_pkg::*;

   logic        clock       = 1'b0;
   logic        rst_n       = 1'b0;
   logic [11:0] address     = 12'h000;
   logic        read        = 1'b0;
   logic        write       = 1'b0;
   logic [3:0]  byteenable  = 4'h1;
   logic [31:0] writedata   = 32'h00000000;
   logic [31:0] readdata;
   logic        waitrequest;
   gevVec_t     globalEvent = 8'h00;
   mboxVec_t    txDone      = 16'h0000;
   mboxVec_t    rxDone      = 16'h0000;
   mboxVec_t    mboxIsRx    = 16'h0000;
   logic        gLine;
   logic        tLine;
   logic        rLine;
   int          nGlobal;
   int          nTx;
   int          nRx;
   int          nWide;
   int          failures    = 0;
   int          n_checks    = 0;
   logic [7:0]  rdv;

   // 250 MHz
   always #2 clock = ~clock;

   can_interrupt_mask_flag_logic can_interrupt_mask_flag_logic_inst (
      .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .globalEvent(globalEvent), .txDone(txDone),
      .rxDone(rxDone), .mboxIsRx(mboxIsRx), .globalIrqLine(gLine),
      .mailboxTxIrqLine(tLine), .mailboxRxIrqLine(rLine));

   irq_sink_model irq_sink_model_inst (
      .clock(clock), .rst_n(rst_n), .globalIrqLine(gLine), .mailboxTxIrqLine(tLine),
      .mailboxRxIrqLine(rLine), .nGlobal(nGlobal), .nTx(nTx), .nRx(nRx), .nWide(nWide));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access: raised after an edge, held until waitrequest is sampled low at an edge
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge clock);
      write     <= wr;
      read      <= ~wr;
      address   <= {idx, 2'b00};
      writedata <= {24'h000000, wd};
      do begin
         @(posedge clock);
         k++;
      end while (waitrequest !== 1'b0 && k < 20);
      if (waitrequest !== 1'b0) begin
         failures++;
         $display("MISMATCH bus waitrequest expected 0 seen 1");
         test_done();
      end
      // read data taken at the same edge that saw waitrequest low, then release
      rdv = readdata[7:0];
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   // one-cycle event pulse, then time for the line pulse to be counted
   task automatic ev(input int g, input logic [15:0] v);
      @(posedge clock);
      if (g == 0) globalEvent <= v[7:0];
      else if (g == 1) txDone <= v;
      else rxDone <= v;
      @(posedge clock);
      globalEvent <= 8'h00;
      txDone      <= 16'h0000;
      rxDone      <= 16'h0000;
      repeat (3) @(posedge clock);
   endtask

   function automatic logic [15:0] cnt(input int g);
      return 16'(g == 0 ? nGlobal : (g == 1 ? nTx : nRx));
   endfunction

   // mailbox group: enables are mb1,3,5,15; mb7 stays disabled
   task automatic grp(input int g, input logic [9:0] base, input mboxVec_t dir);
      logic [15:0] c;
      mboxIsRx <= dir;
      c = cnt(g);
      ev(g, 16'h0008);
      chk("line count first", cnt(g), c + 16'h1);
      bus(1'b0, base, 8'h00);
      chk("flags low", 16'(rdv), 16'h0008);
      ev(g, 16'h00A0);
      chk("line count held", cnt(g), c + 16'h1);
      bus(1'b0, base, 8'h00);
      chk("flags low", 16'(rdv), 16'h0028);
      ev(g, 16'h8000);
      bus(1'b0, base + 10'h1, 8'h00);
      chk("flags high", 16'(rdv), g == 1 ? 16'h0000 : 16'h0080);
      bus(1'b1, base, 8'h00);
      bus(1'b0, base, 8'h00);
      chk("flags after zero write", 16'(rdv), 16'h0028);
      bus(1'b1, base, 8'h08);
      repeat (3) @(posedge clock);
      chk("line count partial clear", cnt(g), c + 16'h2);
      bus(1'b0, base, 8'h00);
      chk("flags after clear", 16'(rdv), 16'h0020);
      mboxIsRx <= dir ^ 16'h0020;
      bus(1'b0, base, 8'h00);
      chk("flag of other direction", 16'(rdv), 16'h0000);
      mboxIsRx <= dir;
      bus(1'b1, base, 8'hFF);
      bus(1'b1, base + 10'h1, 8'hFF);
      repeat (3) @(posedge clock);
      // rx keeps mb15 set across the low clear, so one more pulse there
      chk("line count full clear", cnt(g), g == 1 ? c + 16'h2 : c + 16'h3);
      bus(1'b0, base, 8'h00);
      chk("flags cleared", 16'(rdv), 16'h0000);
   endtask

   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         bus(1'b0, 10'h320 + 10'(i), 8'h00);
         chk("reset value", 16'(rdv), 16'h0000);
      end
      bus(1'b0, 10'h300, 8'h00);
      chk("unmapped read", 16'(rdv), 16'h0000);
      bus(1'b1, 10'h328, 8'h2A);
      bus(1'b1, 10'h329, 8'h80);
      // low byte lane off: answered, but the register keeps its value
      byteenable <= 4'h0;
      bus(1'b1, 10'h329, 8'h7F);
      byteenable <= 4'h1;
      bus(1'b0, 10'h328, 8'h00);
      chk("enable low", 16'(rdv), 16'h002A);
      bus(1'b0, 10'h329, 8'h00);
      chk("enable high", 16'(rdv), 16'h0080);
      $display("reset and enable test done");
      grp(1, 10'h324, 16'h0000);
      $display("transmit group test done");
      grp(2, 10'h326, 16'hFFFF);
      $display("receive group test done");
      chk("global count idle", 16'(nGlobal), 16'h0000);
      bus(1'b1, 10'h322, 8'hFF);
      bus(1'b0, 10'h322, 8'h00);
      chk("mask low", 16'(rdv), 16'h00FF);
      bus(1'b1, 10'h323, 8'hFF);
      bus(1'b0, 10'h323, 8'h00);
      chk("mask high", 16'(rdv), 16'h0000);
      bus(1'b1, 10'h322, 8'h04);
      ev(0, 16'h0001);
      chk("masked event", 16'(nGlobal), 16'h0000);
      bus(1'b0, 10'h320, 8'h00);
      chk("global flags", 16'(rdv), 16'h0001);
      ev(0, 16'h0004);
      chk("enabled event", 16'(nGlobal), 16'h0001);
      bus(1'b1, 10'h322, 8'h14);
      ev(0, 16'h0010);
      chk("second enabled event", 16'(nGlobal), 16'h0001);
      bus(1'b1, 10'h320, 8'h04);
      repeat (3) @(posedge clock);
      chk("global partial clear", 16'(nGlobal), 16'h0002);
      bus(1'b0, 10'h320, 8'h00);
      chk("global flags left", 16'(rdv), 16'h0011);
      chk("wide pulses", 16'(nWide), 16'h0000);
      $display("global group test done");
      // reset again mid-run: the mask written above must come back as zero
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, 10'h322, 8'h00);
      chk("mask after second reset", 16'(rdv), 16'h0000);
      $display("second reset test done");
      test_done();
   end
endmodule // can_interrupt_mask_flag_logic_tb
